// ===== qaw_pkg.sv
// qaw_pkg: shared types and constants of the four-channel analog input word block.
// assumes a 25 MHz core clock and a converter that tags each sample with its channel.
`default_nettype none

package qaw_pkg;

	localparam int unsigned CLK_HZ         = 25000000;
	localparam int unsigned NUM_CHAN       = 4;
	localparam int unsigned DATA_W         = 12;
	localparam int unsigned CHAN_W         = 2;
	localparam int unsigned WORD_W         = 16;

	// word layout
	localparam int unsigned DATA_LSB       = 0;
	localparam int unsigned CHAN_LSB       = 12;
	localparam int unsigned BUSY_BIT       = 14;
	localparam int unsigned SIGN_FAULT_BIT = 15;

	// converter code span
	localparam logic [11:0] CODE_MIN       = 12'h000;
	localparam logic [11:0] CODE_MAX       = 12'hfff;
	localparam int unsigned UNI_DIVISOR    = 4095;
	localparam int unsigned BI_DIVISOR     = 8191;
	// code step in microvolts x100, per span jumper setting
	localparam int unsigned STEP_10V_UV100 = 244;
	localparam int unsigned STEP_5V_UV100  = 122;

	// filter settling: 95 % of a step in this time
	localparam int unsigned SETTLE_TIME_MS = 10;
	localparam int unsigned SETTLE_CYCLES  = SETTLE_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned FILT_SHIFT     = 3;

	localparam int unsigned FIFO_DEPTH     = 32;

	// reset values
	localparam logic [15:0] WORD_RESET     = 16'h4000;
	localparam logic [1:0]  CHAN_FIRST     = 2'h0;

	typedef struct packed {
		logic                fault;
		logic                neg;
		logic [CHAN_W-1:0]   chan;
		logic [DATA_W-1:0]   mag;
	} qaw_sample_s;

	typedef struct packed {
		logic                seen;
		logic                fault;
		logic                neg;
		logic [DATA_W-1:0]   mag;
	} qaw_chan_s;

	typedef struct packed {
		logic                sign_fault;
		logic                busy;
		logic [CHAN_W-1:0]   chan;
		logic [DATA_W-1:0]   data;
	} qaw_word_s;

	typedef enum logic {
		QAW_IDLE,
		QAW_BURST
	} qaw_scan_e;

endpackage

`default_nettype wire

// ===== qaw_fifo.sv
// qaw_fifo: synchronous sample FIFO, valid/ready on both sides.
// assumes one clock; in_ready and out_valid come from flip-flops, out_data is read combinationally from memory.
`timescale 1ns/100ps
`default_nettype none

module qaw_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 32
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             nrst,
	// fill side
	input  wire logic             in_valid,
	output var  logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output var  logic             out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("qaw_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];

	always_comb
	begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			in_ready   <= 1'b0;
			out_valid  <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			// honest flags, registered from the next count
			in_ready  <= count_next != (AW+1)'(DEPTH);
			out_valid <= count_next != '0;
		end
	end
endmodule

`default_nettype wire

// ===== qaw_filter.sv
// qaw_filter: per-channel first-order low-pass on signed converter samples.
// assumes samples arrive with channel tags; read port is combinational from state.
`timescale 1ns/100ps
`default_nettype none

module qaw_filter #(
	parameter int unsigned SHIFT = qaw_pkg::FILT_SHIFT
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// sample input
	input  wire logic                 in_valid,
	output var  logic                 in_ready,
	input  wire qaw_pkg::qaw_sample_s in_sample,
	// read port
	input  wire logic [1:0]           rd_chan,
	output qaw_pkg::qaw_chan_s        rd_entry
);
	localparam int unsigned AW = 13 + SHIFT;

	initial
	begin
		if (SHIFT < 1 || SHIFT > 8)
			$error("qaw_filter: SHIFT must lie in 1..8");
	end

	logic signed [AW-1:0] acc_reg [qaw_pkg::NUM_CHAN];
	logic                 seen_reg [qaw_pkg::NUM_CHAN];
	logic                 fault_reg [qaw_pkg::NUM_CHAN];
	qaw_pkg::qaw_sample_s hold_reg;
	logic                 busy_reg;
	logic signed [AW-1:0] x_s;
	logic signed [AW-1:0] acc_sel;
	logic signed [AW:0]   diff;
	logic signed [12:0]   y;

	// two-cycle read-modify-write; ready drops while the update is pending
	assign in_ready = !busy_reg;
	assign x_s     = AW'($signed({1'b0, hold_reg.mag}) * (hold_reg.neg ? -1 : 1)) <<< SHIFT;
	assign acc_sel = acc_reg[hold_reg.chan];
	assign diff    = (x_s - acc_sel) >>> SHIFT;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_reg <= 1'b0;
			hold_reg <= '0;
		end
		else
		begin
			busy_reg <= in_valid && !busy_reg;
			if (in_valid && !busy_reg)
				hold_reg <= in_sample;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < qaw_pkg::NUM_CHAN; i++)
			begin
				acc_reg[i]   <= '0;
				seen_reg[i]  <= 1'b0;
				fault_reg[i] <= 1'b0;
			end
		end
		else if (busy_reg)
		begin
			fault_reg[hold_reg.chan] <= hold_reg.fault;
			if (!hold_reg.fault)
			begin
				seen_reg[hold_reg.chan] <= 1'b1;
				// first sample preloads so data is valid at once
				acc_reg[hold_reg.chan] <= seen_reg[hold_reg.chan] ? AW'(acc_sel + diff[AW-1:0]) : x_s;
			end
		end
	end

	always_comb
	begin
		y = 13'(acc_reg[rd_chan] >>> SHIFT);
		rd_entry.seen  = seen_reg[rd_chan];
		rd_entry.fault = fault_reg[rd_chan];
		rd_entry.neg   = y[12];
		rd_entry.mag   = y[12] ? 12'(-y) : y[11:0];
	end
endmodule

`default_nettype wire

// ===== qaw_top.sv
// qaw_top: digital front end of a four-channel analog input module.
// assumes the controller pulses scan_start once per scan, synchronous to clock.
`timescale 1ns/100ps
`default_nettype none

module qaw_top #(
	parameter int unsigned SETTLE_CYCLES = qaw_pkg::SETTLE_CYCLES,
	parameter int unsigned FIFO_DEPTH    = qaw_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// converter sample stream
	input  wire logic                 adc_valid,
	output var  logic                 adc_ready,
	input  wire qaw_pkg::qaw_sample_s adc_sample,
	// jumpers and module conditions
	input  wire logic [1:0]           chan_count_jumper,
	input  wire logic                 span_select_jumper,
	input  wire logic                 noise_alarm,
	// analog front end control
	output var  logic                 span_5v_select,
	output var  logic [7:0]           code_step_uv100,
	// controller scan side
	input  wire logic                 scan_start,
	input  wire logic                 pointer_mode,
	output var  logic [15:0]          channel_input_word,
	output var  logic                 word_strobe
);
	localparam int unsigned CW = $clog2(SETTLE_CYCLES + 1);

	initial
	begin
		if (SETTLE_CYCLES < 1)
			$error("qaw_top: SETTLE_CYCLES must be at least 1");
		if (FIFO_DEPTH < 2)
			$error("qaw_top: FIFO_DEPTH must be at least 2");
	end

	// word assembly shared by both transfer modes
	function automatic logic [15:0] make_word(
		input logic [1:0]         chan,
		input qaw_pkg::qaw_chan_s e,
		input logic               stale,
		input logic               busy
	);
		qaw_pkg::qaw_word_s w;
		w.chan = chan;
		w.busy = busy;
		if (e.fault || stale)
		begin
			w.data       = qaw_pkg::CODE_MIN;
			w.sign_fault = 1'b1;
		end
		else
		begin
			w.data       = e.seen ? e.mag : qaw_pkg::CODE_MIN;
			w.sign_fault = e.seen && e.neg && e.mag != qaw_pkg::CODE_MIN;
		end
		make_word = w;
	endfunction

	qaw_pkg::qaw_sample_s fifo_sample;
	qaw_pkg::qaw_chan_s   rd_entry;
	qaw_pkg::qaw_scan_e   scan_state_reg;
	logic                 fifo_valid;
	logic                 fifo_ready;
	logic                 filt_ready;
	logic                 filt_valid;
	logic                 chan_enabled;
	logic [1:0]           last_chan;
	logic [1:0]           mux_chan_reg;
	logic [1:0]           burst_chan_reg;
	logic [1:0]           rd_chan;
	logic                 first_scan_reg;
	logic                 busy_now;
	logic [CW-1:0]        age_reg [qaw_pkg::NUM_CHAN];
	logic                 stale_reg [qaw_pkg::NUM_CHAN];

	// jumper pair gives channel count minus one
	assign last_chan = chan_count_jumper;

	// samples land in the FIFO whenever the converter has them and the FIFO is not full
	qaw_fifo #(
		.WIDTH ($bits(qaw_pkg::qaw_sample_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (adc_valid),
		.in_ready  (adc_ready),
		.in_data   (adc_sample),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_sample)
	);

	// disabled channels are drained and dropped, never filtered
	assign chan_enabled = fifo_sample.chan <= last_chan;
	assign filt_valid   = fifo_valid && chan_enabled;
	assign fifo_ready   = chan_enabled ? filt_ready : 1'b1;

	qaw_filter #(
		.SHIFT (qaw_pkg::FILT_SHIFT)
	) u_filter (
		.clock     (clock),
		.nrst      (nrst),
		.in_valid  (filt_valid),
		.in_ready  (filt_ready),
		.in_sample (fifo_sample),
		.rd_chan   (rd_chan),
		.rd_entry  (rd_entry)
	);

	// a channel that delivers nothing for a settling window counts as failed
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < qaw_pkg::NUM_CHAN; i++)
			begin
				age_reg[i]   <= '0;
				stale_reg[i] <= 1'b0;
			end
		end
		else
		begin
			for (int i = 0; i < qaw_pkg::NUM_CHAN; i++)
			begin
				if (filt_valid && filt_ready && fifo_sample.chan == 2'(i))
				begin
					age_reg[i]   <= '0;
					stale_reg[i] <= 1'b0;
				end
				else if (age_reg[i] == CW'(SETTLE_CYCLES))
					stale_reg[i] <= 1'b1;
				else
					age_reg[i] <= age_reg[i] + 1'b1;
			end
		end
	end

	// span jumper steers the analog gain; step size follows it
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			span_5v_select  <= 1'b0;
			code_step_uv100 <= 8'(qaw_pkg::STEP_10V_UV100);
		end
		else
		begin
			span_5v_select  <= span_select_jumper;
			code_step_uv100 <= span_select_jumper ? 8'(qaw_pkg::STEP_5V_UV100)
			                                      : 8'(qaw_pkg::STEP_10V_UV100);
		end
	end

	// noise holds busy after the first scan
	assign busy_now = first_scan_reg || noise_alarm;
	// pointer scan opens on channel 1 straight from the filter, never from a stale copy
	assign rd_chan  = (scan_state_reg == qaw_pkg::QAW_BURST) ? burst_chan_reg
	                : (scan_start && pointer_mode) ? qaw_pkg::CHAN_FIRST : mux_chan_reg;

	// first scan marker, cleared as the first word of the first scan goes out
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			first_scan_reg <= 1'b1;
		else if (scan_start && scan_state_reg == qaw_pkg::QAW_IDLE)
			first_scan_reg <= 1'b0;
	end

	// scan sequencer
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			scan_state_reg <= qaw_pkg::QAW_IDLE;
			mux_chan_reg   <= qaw_pkg::CHAN_FIRST;
			burst_chan_reg <= qaw_pkg::CHAN_FIRST;
		end
		else
		begin
			unique case (scan_state_reg)
				qaw_pkg::QAW_IDLE:
				begin
					if (scan_start && pointer_mode && last_chan != qaw_pkg::CHAN_FIRST)
					begin
						scan_state_reg <= qaw_pkg::QAW_BURST;
						burst_chan_reg <= qaw_pkg::CHAN_FIRST + 2'h1;
					end
					else if (scan_start && !pointer_mode)
					begin
						// one channel per scan, wrap past the last enabled one
						if (mux_chan_reg >= last_chan)
							mux_chan_reg <= qaw_pkg::CHAN_FIRST;
						else
							mux_chan_reg <= mux_chan_reg + 2'h1;
					end
				end
				qaw_pkg::QAW_BURST:
				begin
					if (burst_chan_reg >= last_chan)
						scan_state_reg <= qaw_pkg::QAW_IDLE;
					else
						burst_chan_reg <= burst_chan_reg + 2'h1;
				end
			endcase
		end
	end

	// output word and strobe; pointer mode starts its burst at channel 1
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			channel_input_word <= qaw_pkg::WORD_RESET;
			word_strobe        <= 1'b0;
		end
		else if (scan_state_reg == qaw_pkg::QAW_BURST)
		begin
			channel_input_word <= make_word(burst_chan_reg, rd_entry, stale_reg[burst_chan_reg],
			                                busy_now || !rd_entry.seen);
			word_strobe        <= 1'b1;
		end
		else if (scan_start)
		begin
			// pointer mode reads from channel 1, multiplexing from the current one
			channel_input_word <= make_word(rd_chan, rd_entry, stale_reg[rd_chan],
			                                busy_now || !rd_entry.seen);
			word_strobe        <= 1'b1;
		end
		else
			word_strobe        <= 1'b0;
	end

endmodule

`default_nettype wire

// ===== qaw_monitor.sv
// qaw_monitor: port-level assertions for the analog input word block.
// assumes it is bound into qaw_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module qaw_monitor #(
	parameter int unsigned SETTLE_CYCLES = qaw_pkg::SETTLE_CYCLES,
	parameter int unsigned FIFO_DEPTH    = qaw_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 nrst,
	// converter stream
	input  wire logic                 adc_valid,
	input  wire logic                 adc_ready,
	input  wire qaw_pkg::qaw_sample_s adc_sample,
	// jumpers and conditions
	input  wire logic [1:0]           chan_count_jumper,
	input  wire logic                 span_select_jumper,
	input  wire logic                 noise_alarm,
	input  wire logic                 span_5v_select,
	input  wire logic [7:0]           code_step_uv100,
	// controller side
	input  wire logic                 scan_start,
	input  wire logic                 pointer_mode,
	input  wire logic [15:0]          channel_input_word,
	input  wire logic                 word_strobe
);
	logic first_done;

	// remembers whether any word went out since reset
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			first_done <= 1'b0;
		else if (word_strobe)
			first_done <= 1'b1;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	property p_mux_answer;
		scan_start && !pointer_mode && !word_strobe |=> word_strobe;
	endproperty
	a_mux_answer: assert property (p_mux_answer) else $error("no word after scan marker");
	property p_mux_single;
		scan_start && !pointer_mode ##1 word_strobe |=> !word_strobe;
	endproperty
	a_mux_single: assert property (p_mux_single) else $error("more than one word in a mux scan");
	property p_word_holds;
		$changed(channel_input_word) |-> word_strobe;
	endproperty
	a_word_holds: assert property (p_word_holds) else $error("word changed without strobe");
	property p_ptr_burst;
		scan_start && pointer_mode && chan_count_jumper == 2'h3 && !word_strobe |=> word_strobe [*4] ##1 !word_strobe;
	endproperty
	a_ptr_burst: assert property (p_ptr_burst) else $error("pointer burst not four words");
	property p_ptr_first;
		scan_start && pointer_mode && !word_strobe |=> channel_input_word[13:12] == 2'h0;
	endproperty
	a_ptr_first: assert property (p_ptr_first) else $error("burst does not open with first channel");
	property p_chan_step;
		word_strobe ##1 word_strobe |-> channel_input_word[13:12] == $past(channel_input_word[13:12]) + 2'h1;
	endproperty
	a_chan_step: assert property (p_chan_step) else $error("channel code out of order");
	property p_chan_limit;
		word_strobe |-> channel_input_word[13:12] <= chan_count_jumper;
	endproperty
	a_chan_limit: assert property (p_chan_limit) else $error("disabled channel presented");
	property p_span;
		$stable(span_select_jumper) [*3] |-> span_5v_select == span_select_jumper
			&& code_step_uv100 == (span_select_jumper ? 8'h7a : 8'hf4);
	endproperty
	a_span: assert property (p_span) else $error("span select or code step wrong");
	property p_noise_busy;
		scan_start && !pointer_mode && noise_alarm |=> word_strobe && channel_input_word[14];
	endproperty
	a_noise_busy: assert property (p_noise_busy) else $error("busy missing under noise");
	property p_first_busy;
		word_strobe && !first_done |-> channel_input_word[14];
	endproperty
	a_first_busy: assert property (p_first_busy) else $error("first word not busy");
endmodule

bind qaw_top qaw_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_qaw_monitor (
	.clock(clock), .nrst(nrst), .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_sample(adc_sample),
	.chan_count_jumper(chan_count_jumper), .span_select_jumper(span_select_jumper), .noise_alarm(noise_alarm),
	.span_5v_select(span_5v_select), .code_step_uv100(code_step_uv100), .scan_start(scan_start),
	.pointer_mode(pointer_mode), .channel_input_word(channel_input_word), .word_strobe(word_strobe));

`default_nettype wire

// ===== qaw_ctrl_model.sv
// qaw_ctrl_model: controller side, raises scan markers and collects words.
// assumes the bench asks for scans and reads the seen queue.
`timescale 1ns/100ps
`default_nettype none

module qaw_ctrl_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        nrst,
	// bench request
	input  wire logic        scan_req,
	// device side
	output var  logic        scan_start,
	input  wire logic [15:0] channel_input_word,
	input  wire logic        word_strobe
);
	logic [15:0] seen[$];
	int          fail_cnt;

	// one-cycle marker per request
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			scan_start <= 1'b0;
		else
			scan_start <= scan_req;
	end

	// every strobe is taken; a burst brings all enabled channels in one scan
	always @(posedge clock)
	begin
		if (nrst && word_strobe)
		begin
			seen.push_back(channel_input_word);
			if (channel_input_word[15] && channel_input_word[11:0] == 12'h000)
				fail_cnt++;
		end
	end
endmodule

`default_nettype wire

// ===== qaw_top_tb_top.sv
// qaw_top_tb_top: self-checking bench for the analog input word block.
// assumes qaw_monitor is bound in and qaw_ctrl_model plays the controller.
`timescale 1ns/100ps
`default_nettype none

module qaw_top_tb_top;
	typedef struct {
		logic        noise;
		logic [15:0] exp;
	} qaw_row_s;

	logic                 clock = 1'b0;
	logic                 nrst = 1'b0;
	logic                 adc_valid = 1'b0;
	logic                 adc_ready;
	qaw_pkg::qaw_sample_s adc_sample = '0;
	logic [1:0]           chan_count_jumper = 2'h3;
	logic                 span_select_jumper = 1'b0;
	logic                 noise_alarm = 1'b0;
	logic                 span_5v_select;
	logic [7:0]           code_step_uv100;
	logic                 scan_start;
	logic                 scan_req = 1'b0;
	logic                 pointer_mode = 1'b0;
	logic [15:0]          channel_input_word;
	logic                 word_strobe;
	int                   failures = 0;
	int                   n_tests = 0;
	int                   cycles = 0;
	int                   refused;
	// ch2 negative, ch3 failed, ch4 full scale
	qaw_row_s             rows[5] = '{'{1'b0, 16'h9456}, '{1'b1, 16'he000}, '{1'b0, 16'h3fff},
		'{1'b0, 16'h0123}, '{1'b0, 16'h9456}};
	// ch3 never converted, so busy stays set beside its failure flag
	logic [15:0]          ptr_exp[4] = '{16'h0123, 16'h9456, 16'he000, 16'h3fff};
	logic [15:0]          two_exp[3] = '{16'h9456, 16'h0123, 16'h9456};

	// settle count cut short so that staleness shows within a few hundred cycles
	qaw_top #(.SETTLE_CYCLES(300), .FIFO_DEPTH(32)) u_qaw_top (.clock(clock), .nrst(nrst),
		.adc_valid(adc_valid), .adc_ready(adc_ready), .adc_sample(adc_sample),
		.chan_count_jumper(chan_count_jumper), .span_select_jumper(span_select_jumper),
		.noise_alarm(noise_alarm), .span_5v_select(span_5v_select), .code_step_uv100(code_step_uv100),
		.scan_start(scan_start), .pointer_mode(pointer_mode), .channel_input_word(channel_input_word),
		.word_strobe(word_strobe));
	qaw_ctrl_model u_qaw_ctrl_model (.clock(clock), .nrst(nrst), .scan_req(scan_req), .scan_start(scan_start),
		.channel_input_word(channel_input_word), .word_strobe(word_strobe));

	always #20 clock = ~clock;

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			finish_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic do_reset(input logic [1:0] jmp, input logic span);
		#1 nrst = 1'b0;
		chan_count_jumper = jmp;
		span_select_jumper = span;
		repeat (3) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (2) @(posedge clock);
		u_qaw_ctrl_model.seen.delete();
	endtask

	// sample is held until an edge sees room
	task automatic push(input logic fault, input logic neg, input logic [1:0] ch, input logic [11:0] mag);
		#1 adc_sample = '{fault, neg, ch, mag};
		adc_valid = 1'b1;
		@(posedge clock);
		while (adc_ready !== 1'b1)
			@(posedge clock);
	endtask

	task automatic scan(input logic pm, input logic noise);
		#1 scan_req = 1'b1;
		pointer_mode = pm;
		noise_alarm = noise;
		@(posedge clock);
		#1 scan_req = 1'b0;
		repeat (8) @(posedge clock);
	endtask

	initial
	begin
		do_reset(2'h3, 1'b0);
		scan(1'b0, 1'b0);
		chk(u_qaw_ctrl_model.seen.pop_front(), 16'h4000);
		chk({8'h00, code_step_uv100}, 16'h00f4);
		chk({15'h0, span_5v_select}, 16'h0000);
		push(1'b0, 1'b0, 2'h0, 12'h123);
		push(1'b0, 1'b1, 2'h1, 12'h456);
		push(1'b1, 1'b0, 2'h2, 12'h789);
		push(1'b0, 1'b0, 2'h3, 12'hfff);
		#1 adc_valid = 1'b0;
		repeat (20) @(posedge clock);
		foreach (rows[i])
		begin
			scan(1'b0, rows[i].noise);
			chk(u_qaw_ctrl_model.seen.pop_front(), rows[i].exp);
		end
		$display("mux sequence done");
		// second marker lands mid burst and must be ignored
		#1 scan_req = 1'b1;
		pointer_mode = 1'b1;
		@(posedge clock);
		#1 scan_req = 1'b0;
		@(posedge clock);
		#1 scan_req = 1'b1;
		@(posedge clock);
		#1 scan_req = 1'b0;
		repeat (8) @(posedge clock);
		chk(16'(u_qaw_ctrl_model.seen.size()), 16'h0004);
		foreach (ptr_exp[i])
			chk(u_qaw_ctrl_model.seen.pop_front(), ptr_exp[i]);
		$display("pointer burst done");
		repeat (320) @(posedge clock);
		scan(1'b1, 1'b0);
		for (int i = 0; i < 4; i++)
			chk(u_qaw_ctrl_model.seen.pop_front(), {4'h8 | 4'(i) | (i == 2 ? 4'h4 : 4'h0), 12'h000});
		$display("stale channels done");
		do_reset(2'h1, 1'b1);
		scan(1'b0, 1'b0);
		chk(u_qaw_ctrl_model.seen.pop_front(), 16'h4000);
		chk({8'h00, code_step_uv100}, 16'h007a);
		chk({15'h0, span_5v_select}, 16'h0001);
		refused = 0;
		#1 adc_sample = '{1'b0, 1'b0, 2'h0, 12'h123};
		adc_valid = 1'b1;
		repeat (100)
		begin
			@(posedge clock);
			if (adc_ready !== 1'b1)
				refused++;
		end
		#1 adc_valid = 1'b0;
		repeat (150) @(posedge clock);
		chk({15'h0, refused > 0}, 16'h0001);
		chk({15'h0, adc_ready}, 16'h0001);
		push(1'b0, 1'b1, 2'h1, 12'h456);
		push(1'b0, 1'b0, 2'h2, 12'h789);
		#1 adc_valid = 1'b0;
		repeat (20) @(posedge clock);
		foreach (two_exp[i])
		begin
			scan(1'b0, 1'b0);
			chk(u_qaw_ctrl_model.seen.pop_front(), two_exp[i]);
		end
		$display("two channel and buffer done");
		finish_test();
	end
endmodule

`default_nettype wire
